// ===== pie_core_model.sv
// Behavioural processor core that takes vectors from the block
`timescale 1ns/10ps
module pie_core_model (
	// Clock and reset
	input wire logic                      sys_clk,
	input wire logic                      rst_n,
	// Bench control
	input wire logic                      ackEn,
	input wire logic [3:0]                ackWait,
	// Block side
	input wire pie_pkg::pie_core_irq_type coreIrq,
	output logic                          coreAck,
	output logic [pie_pkg::SRC_W-1:0]     tookVec
);
	logic [3:0] waitQ;
	initial begin
		coreAck = 1'b0;
		tookVec = '0;
		waitQ = 4'h0;
	end
	// Slow or prompt taking of a presented vector
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			waitQ   <= 4'h0;
			coreAck <= 1'b0;
		end else if (coreIrq.valid && ackEn && !coreAck) begin
			waitQ   <= (waitQ == ackWait) ? 4'h0 : waitQ + 4'h1;
			coreAck <= (waitQ == ackWait);
			if (waitQ == ackWait) begin
				tookVec <= coreIrq.vector;
			end
		end else begin
			coreAck <= 1'b0;
		end
	end
endmodule

// ===== pie_intc.sv
// Top of the prioritized interrupt enable block with its APB register file
//
// Summary of operation
// RULE_01: Upper enable clear, lower enable set: source enabled at low priority.
// RULE_02: Upper enable set, lower enable clear: source enabled at nominal priority.
// RULE_03: Both enable bits set: source enabled at high priority.
// RULE_04: Both enable bits clear: source disabled, never presented to the core.
// RULE_05: Enables and requests live in banks, one bit per source, chosen by bank.
// RULE_06: Latched, enabled request with global enable raises vectored interrupt to core.
// RULE_07: Software clears a request bit to dismiss it; it is then not presented.
// RULE_08: Edge-select bit clear: pin source latches a request on a falling edge.
// RULE_09: Edge-select bit set: pin source latches a request on a rising edge.
// RULE_10: Source-select bit clear: first source drives shared line, second ignored.
// RULE_11: Source-select bit set: second source drives shared line, first ignored.
// RULE_12: Seven shared lines: four port pin pairs, three pin with comparator or detector.
// RULE_13: Every per-source bit is written independently of the other sources; here a write replaces the whole register byte at once.
`timescale 1ns/10ps
module pie_intc (
	// Clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// APB slave
	input  wire logic [pie_pkg::ADDR_W-1:0]    paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [pie_pkg::DATA_W-1:0]    pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [pie_pkg::DATA_W-1:0]    prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Peripheral event pulses, same clock
	input  wire logic [pie_pkg::NUM_SRC-1:0]   periphEvt,
	input  wire logic                          comparatorAEvt,
	input  wire logic                          comparatorBEvt,
	input  wire logic                          lowVoltEvt,
	// Asynchronous port pins, lines 1..7 and 1..4
	input  wire logic [pie_pkg::SHARED_LINES-1:0] firstPortPin,
	input  wire logic [pie_pkg::PORT2_LINES-1:0]  secondPortPin,
	// Processor core
	input  wire logic                          coreAck,
	output pie_pkg::pie_core_irq_type          coreIrq,
	// Block interrupt
	output logic                               irqOut
);

	localparam int NB = pie_pkg::NUM_BANKS;
	localparam int SP = pie_pkg::SRC_PER_BANK;
	localparam int SL = pie_pkg::SHARED_LINES;
	localparam int NE = pie_pkg::NUM_EVT;

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [NB-1:0][SP-1:0]         upper_q, upper_d;
	logic [NB-1:0][SP-1:0]         lower_q, lower_d;
	logic [NB-1:0][SP-1:0]         req_q, req_d;
	logic                          globalEn_q, globalEn_d;
	logic [SL-1:0]                 edgePol_q, edgePol_d;
	logic [SL-1:0]                 share_q, share_d;
	logic [NE-1:0]                 stat_q, stat_d;
	logic [NE-1:0]                 mask_q, mask_d;
	logic [pie_pkg::DATA_W-1:0]    prdata_q;
	logic                          pready_q;
	logic                          pslverr_q;
	pie_pkg::pie_core_irq_type     coreIrq_q, coreIrq_d;
	logic                          irqOut_q;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode
	function automatic logic inBank(input logic [pie_pkg::ADDR_W-1:0] a);
		return a >= pie_pkg::BANK_BASE && a < pie_pkg::BANK_END && a[1:0] == 2'h0 &&
			a[3:0] <= pie_pkg::REQ_OFF;
	endfunction

	function automatic logic [pie_pkg::BANK_W-1:0] bankOf(
		input logic [pie_pkg::ADDR_W-1:0] a);
		logic [pie_pkg::ADDR_W-1:0] rel;
		rel = (a - pie_pkg::BANK_BASE) >> pie_pkg::BANK_SHIFT;
		return rel[pie_pkg::BANK_W-1:0];
	endfunction

	wire                        setupSeen = psel & penable & ~pready_q;
	wire                        commit    = psel & penable & pready_q;
	wire                        wrCommit  = commit & pwrite & pstrb[0];
	wire                        bankHit   = inBank(paddr);
	wire [pie_pkg::BANK_W-1:0]  bankIdx   = bankOf(paddr);
	wire [3:0]                  regOff    = paddr[3:0];
	wire                        hitCtrl   = paddr == pie_pkg::CTRL_OFF;
	wire                        hitEdge   = paddr == pie_pkg::EDGE_OFF;
	wire                        hitShare  = paddr == pie_pkg::SHARE_OFF;
	wire                        hitStat   = paddr == pie_pkg::STAT_OFF;
	wire                        hitMask   = paddr == pie_pkg::MASK_OFF;
	wire                        hitCore   = paddr == pie_pkg::CORE_OFF;
	wire                        mapped    = hitCtrl | hitEdge | hitShare | hitStat |
		hitMask | hitCore | bankHit;
	wire [SP-1:0]               wByte     = pwdata[SP-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Read data
	wire [SP-1:0] bankByte = (regOff == pie_pkg::UPPER_OFF) ? upper_q[bankIdx] :
		(regOff == pie_pkg::LOWER_OFF) ? lower_q[bankIdx] : req_q[bankIdx]; // see RULE_05
	wire [SP-1:0] readByte =
		hitCtrl  ? {7'h00, globalEn_q} :
		hitEdge  ? {edgePol_q, 1'b0} :
		hitShare ? {share_q, 1'b0} :
		hitStat  ? {5'h00, stat_q} :
		hitMask  ? {5'h00, mask_q} :
		hitCore  ? coreIrq_q :
		bankHit  ? bankByte : 8'h00;
	wire [pie_pkg::DATA_W-1:0] readWord = {24'h000000, readByte};

	////////////////////////////////////////////////////////////////////////////////
	// Pin edges and shared lines
	logic [pie_pkg::NUM_PINS-1:0] pinHit;

	pie_pin_edge #(
		.WIDTH     (pie_pkg::NUM_PINS)
	) uPinEdge (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pinIn     ({secondPortPin, firstPortPin}),
		.risingSel ({edgePol_q[pie_pkg::PORT2_LINES-1:0], edgePol_q}),
		.edgeHit   (pinHit)
	);

	// Lines 5..7 pair a pin with comparator B, comparator A and the low-voltage detector
	wire [SL-1:0] firstSrc  = pinHit[SL-1:0];
	wire [SL-1:0] secondSrc = {lowVoltEvt, comparatorAEvt, comparatorBEvt,
		pinHit[pie_pkg::NUM_PINS-1:SL]}; // see RULE_12
	wire [SL-1:0] sharedHit = (share_q & secondSrc) | (~share_q & firstSrc); // see RULE_10 see RULE_11

	// Shared lines replace bits 7..1 of their bank; those peripheral inputs are unused
	logic [NB-1:0][SP-1:0] srcEvt;
	genvar b;
	generate
		for (b = 0; b < NB; b++) begin : gSrc
			if (b == pie_pkg::SHARED_BANK) begin : gShared
				assign srcEvt[b] = {sharedHit, periphEvt[b*SP]};
			end else begin : gPlain
				assign srcEvt[b] = periphEvt[b*SP +: SP];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Bank register updates
	logic [NB-1:0][SP-1:0] swClr;
	logic [pie_pkg::NUM_SRC-1:0] ackClr;

	wire coreTaken = coreAck & coreIrq_q.valid;
	assign ackClr = coreTaken ? (32'h00000001 << coreIrq_q.vector) : 32'h00000000;

	generate
		for (b = 0; b < NB; b++) begin : gBank
			wire sel   = wrCommit & bankHit & (bankIdx == pie_pkg::BANK_W'(b));
			wire wrUp  = sel & (regOff == pie_pkg::UPPER_OFF);
			wire wrLo  = sel & (regOff == pie_pkg::LOWER_OFF);
			wire wrReq = sel & (regOff == pie_pkg::REQ_OFF);
			// Each bit is its own flop, so a write touches only this bank
			assign upper_d[b] = wrUp ? wByte : upper_q[b]; // see RULE_13
			assign lower_d[b] = wrLo ? wByte : lower_q[b]; // see RULE_13
			// Writing zero dismisses; writing one leaves the bit alone
			assign swClr[b]   = wrReq ? ~wByte : 8'h00; // see RULE_07
			// A new event in the clearing cycle still latches
			assign req_d[b]   = (req_q[b] & ~swClr[b] & ~ackClr[b*SP +: SP]) | srcEvt[b];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Control registers
	assign globalEn_d = (wrCommit & hitCtrl) ? wByte[0] : globalEn_q;
	assign edgePol_d  = (wrCommit & hitEdge) ? wByte[SP-1:1] : edgePol_q; // see RULE_13
	assign share_d    = (wrCommit & hitShare) ? wByte[SP-1:1] : share_q; // see RULE_13
	assign mask_d     = (wrCommit & hitMask) ? wByte[NE-1:0] : mask_q;

	// Event status, write one to clear, set wins over clear
	wire [NE-1:0] evt;
	assign evt[pie_pkg::EVT_LATCH]   = |(srcEvt & ~req_q);
	assign evt[pie_pkg::EVT_DISMISS] = |(swClr & req_q);
	assign evt[pie_pkg::EVT_TAKEN]   = coreTaken;
	wire [NE-1:0] statClr = (wrCommit & hitStat) ? wByte[NE-1:0] : 3'h0;
	assign stat_d = (stat_q & ~statClr) | evt;

	////////////////////////////////////////////////////////////////////////////////
	// Core request
	logic                          pickHit;
	pie_pkg::pie_level_type        pickLevel;
	logic [pie_pkg::SRC_W-1:0]     pickVector;

	pie_prio_pick #(
		.N        (pie_pkg::NUM_SRC),
		.SW       (pie_pkg::SRC_W)
	) uPick (
		.req      (req_d),
		.upper    (upper_q),
		.lower    (lower_q),
		.globalEn (globalEn_q),
		.hit      (pickHit),
		.level    (pickLevel),
		.vector   (pickVector)
	);

	// Drop the request in the acknowledge cycle so the same vector is not taken twice
	assign coreIrq_d.valid  = pickHit & ~coreTaken; // see RULE_06
	assign coreIrq_d.level  = pickLevel;
	assign coreIrq_d.vector = pickVector;

	////////////////////////////////////////////////////////////////////////////////
	// Flops
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			upper_q <= {NB{pie_pkg::ENABLE_RST}};
		end else begin
			upper_q <= upper_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lower_q <= {NB{pie_pkg::ENABLE_RST}};
		end else begin
			lower_q <= lower_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			req_q <= {NB{pie_pkg::REQ_RST}};
		end else begin
			req_q <= req_d;
		end
	end

	// Global enable comes up off so nothing reaches the core before setup
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			globalEn_q <= 1'b0;
		end else begin
			globalEn_q <= globalEn_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			edgePol_q <= pie_pkg::EDGE_RST;
		end else begin
			edgePol_q <= edgePol_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			share_q <= pie_pkg::SHARE_RST;
		end else begin
			share_q <= share_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			stat_q <= pie_pkg::STAT_RST;
		end else begin
			stat_q <= stat_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mask_q <= pie_pkg::MASK_RST;
		end else begin
			mask_q <= mask_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			coreIrq_q <= '0;
		end else begin
			coreIrq_q <= coreIrq_d;
		end
	end

	// Built from next values, so the level changes on the same edge as status
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irqOut_q <= 1'b0;
		end else begin
			irqOut_q <= |(stat_d & mask_d);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One wait state: answer registered in the first access cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setupSeen;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= setupSeen & ~mapped;
		end
	end

	// Read data is zero outside the answer so a stale word never leaks
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata_q <= '0;
		end else begin
			prdata_q <= (setupSeen & ~pwrite & mapped) ? readWord : 32'h00000000;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign coreIrq = coreIrq_q;
	assign irqOut  = irqOut_q;

endmodule

// ===== pie_intc_bench.sv
// Self-checking bench for the prioritized interrupt enable block
`timescale 1ns/10ps
module pie_intc_bench;
	logic                      sys_clk   = 1'b0;
	logic                      rst_n     = 1'b0;
	logic [7:0]                paddr     = 8'h00;
	logic                      psel      = 1'b0;
	logic                      penable   = 1'b0;
	logic                      pwrite    = 1'b0;
	logic [31:0]               pwdata    = 32'h0;
	logic [31:0]               periphEvt = 32'h0;
	logic [2:0]                secEvt    = 3'h0;
	logic [6:0]                pinA      = 7'h00;
	logic [3:0]                pinB      = 4'h0;
	logic                      ackEn     = 1'b0;
	logic [31:0]               prdata;
	logic                      pready;
	logic                      pslverr;
	logic                      coreAck;
	logic                      irqOut;
	logic [4:0]                tookVec;
	pie_pkg::pie_core_irq_type coreIrq;
	logic [31:0]               rdv;
	logic                      errv;
	int                        badCount  = 0;
	int                        numChecks = 0;
	int                        cyc       = 0;

	pie_intc dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .periphEvt(periphEvt), .comparatorAEvt(secEvt[1]),
		.comparatorBEvt(secEvt[0]), .lowVoltEvt(secEvt[2]), .firstPortPin(pinA),
		.secondPortPin(pinB), .coreAck(coreAck), .coreIrq(coreIrq), .irqOut(irqOut));
	pie_core_model core_u (.sys_clk(sys_clk), .rst_n(rst_n), .ackEn(ackEn), .ackWait(4'h2),
		.coreIrq(coreIrq), .coreAck(coreAck), .tookVec(tookVec));

	always #2.5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		numChecks++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Waits for the answer; only the bound ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check({31'h0, n < 20}, 32'h1, "answer");
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		apb(1'b0, a, 8'h00);
		check(rdv, {24'h0, exp}, what);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic pulse(input logic [34:0] v);
		@(posedge sys_clk);
		{secEvt, periphEvt} <= v;
		@(posedge sys_clk);
		{secEvt, periphEvt} <= 35'h0;
	endtask
	// Level and vector only mean something while valid
	task automatic irqChk(input logic v, input logic [1:0] l, input logic [4:0] x);
		check({24'h0, coreIrq} & (v ? 32'hff : 32'h80), {24'h0, v, (v ? {l, x} : 7'h00)},
			"core irq");
	endtask
	function automatic logic [7:0] bk(input int b, input int o);
		return pie_pkg::BANK_BASE + 8'(b * 16 + o);
	endfunction
	task automatic reportAndStop;
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			badCount++;
			reportAndStop();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] regs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28};
		tick(4);
		rst_n <= 1'b1;
		foreach (regs[i]) rd(regs[i], 8'h00, "reset value");
		apb(1'b0, 8'h18, 8'h00);
		check({31'h0, errv}, 32'h1, "hole refused");
		$display("test reset and map done");
		wr(pie_pkg::CTRL_OFF, 8'h01);
		for (int lv = 0; lv < 4; lv++) begin
			wr(bk(0, 0), lv[1] ? 8'h08 : 8'h00);
			wr(bk(0, 4), lv[0] ? 8'h08 : 8'h00);
			pulse(35'h1 << 3);
			tick(3);
			irqChk(lv != 0, 2'(lv), 5'd3);
			wr(bk(0, 8), 8'hf7);
			tick(2);
			irqChk(1'b0, 2'h0, 5'h0);
			rd(bk(0, 8), 8'h00, "dismissed");
		end
		wr(pie_pkg::CTRL_OFF, 8'h00);
		pulse(35'h1 << 3);
		tick(3);
		irqChk(1'b0, 2'h0, 5'h0);
		wr(pie_pkg::CTRL_OFF, 8'h01);
		tick(3);
		irqChk(1'b1, 2'h3, 5'd3);
		ackEn <= 1'b1;
		tick(8);
		check({27'h0, tookVec}, 32'd3, "vector taken");
		rd(bk(0, 8), 8'h00, "taken request");
		ackEn <= 1'b0;
		$display("test levels done");
		wr(bk(2, 0), 8'h20);
		wr(bk(2, 4), 8'h20);
		rd(bk(0, 0), 8'h08, "other bank kept");
		pulse(35'h1 << 21);
		tick(3);
		irqChk(1'b1, 2'h3, 5'd21);
		wr(bk(2, 8), 8'hdf);
		rd(bk(2, 8), 8'h00, "bank clear");
		$display("test banks done");
		pinA[0] <= 1'b1;
		tick(8);
		rd(bk(1, 8), 8'h00, "rise ignored");
		pinA[0] <= 1'b0;
		tick(8);
		rd(bk(1, 8), 8'h02, "fall latched");
		wr(bk(1, 8), 8'hfd);
		wr(pie_pkg::EDGE_OFF, 8'h02);
		pinA[0] <= 1'b1;
		tick(8);
		rd(bk(1, 8), 8'h02, "rise latched");
		wr(bk(1, 8), 8'h00);
		$display("test edges done");
		for (int k = 0; k < 3; k++) begin
			wr(pie_pkg::SHARE_OFF, 8'h00);
			pulse(35'h1 << (34 - k));
			tick(3);
			rd(bk(1, 8), 8'h00, "second ignored");
			wr(pie_pkg::SHARE_OFF, 8'h80 >> k);
			pulse(35'h1 << (34 - k));
			tick(3);
			rd(bk(1, 8), 8'h80 >> k, "second routed");
			wr(bk(1, 8), 8'h00);
		end
		wr(pie_pkg::SHARE_OFF, 8'h02);
		pinA[0] <= 1'b0;
		tick(8);
		pinA[0] <= 1'b1;
		tick(8);
		rd(bk(1, 8), 8'h00, "first ignored");
		pinB[0] <= 1'b1;
		tick(8);
		rd(bk(1, 8), 8'h02, "port two routed");
		$display("test sharing done");
		rd(pie_pkg::STAT_OFF, 8'h07, "status");
		check({31'h0, irqOut}, 32'h0, "masked irq");
		wr(pie_pkg::MASK_OFF, 8'h01);
		tick(2);
		check({31'h0, irqOut}, 32'h1, "raised irq");
		wr(pie_pkg::STAT_OFF, 8'h01);
		tick(2);
		check({31'h0, irqOut}, 32'h0, "cleared irq");
		rd(pie_pkg::STAT_OFF, 8'h06, "status after clear");
		$display("test interrupt done");
		reportAndStop();
	end
endmodule

// ===== pie_intc_checker.sv
// Port-level assertions for the prioritized interrupt enable block
`timescale 1ns/10ps
module pie_intc_checker (
	// Clock and reset
	input wire logic                       sys_clk,
	input wire logic                       rst_n,
	// APB
	input wire logic [pie_pkg::ADDR_W-1:0] paddr,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic [pie_pkg::DATA_W-1:0] prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	// Core side
	input wire logic                       coreAck,
	input wire pie_pkg::pie_core_irq_type  coreIrq,
	input wire logic                       irqOut
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic holeAddr;
	wire logic mapAddr;
	// Bank spare words left out, though the block also answers them with an error
	assign holeAddr = (paddr == 8'h18) || (paddr == 8'h1c) || (paddr >= 8'h60);
	assign mapAddr  = (paddr <= 8'h14) && (paddr[1:0] == 2'h0);
	////////////////////////////////////////////////////////////////////////////////
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("answer not one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_hole_error: assert property (psel && penable && pready && holeAddr |-> pslverr)
		else $error("hole not refused");
	a_map_clean: assert property (psel && penable && pready && mapAddr |-> !pslverr)
		else $error("mapped word refused");
	a_level_on: assert property (coreIrq.valid |-> coreIrq.level != pie_pkg::LVL_OFF)
		else $error("disabled source presented");
	a_ack_drop: assert property (coreAck && coreIrq.valid |=> !coreIrq.valid)
		else $error("vector kept after ack");
	a_reset_quiet: assert property (@(posedge sys_clk) disable iff (1'b0)
		!rst_n |=> !pready && !coreIrq.valid && !irqOut)
		else $error("outputs busy after reset");
endmodule
bind pie_intc pie_intc_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.coreAck(coreAck), .coreIrq(coreIrq), .irqOut(irqOut));

// ===== pie_pin_edge.sv
// Pin synchroniser and selectable rising or falling edge detector
`timescale 1ns/10ps
module pie_pin_edge #(
	parameter int WIDTH = 11
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Pins and edge choice
	input  wire logic [WIDTH-1:0] pinIn,
	input  wire logic [WIDTH-1:0] risingSel,
	// One-cycle edge pulses
	output logic      [WIDTH-1:0] edgeHit
);

	logic [WIDTH-1:0] syncA_q;
	logic [WIDTH-1:0] syncB_q;
	logic [WIDTH-1:0] prev_q;

	// Only syncB reads syncA; the detector looks at syncB and prev
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
			prev_q  <= '0;
		end else begin
			syncA_q <= pinIn;
			syncB_q <= syncA_q;
			prev_q  <= syncB_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gEdge
			wire rise = syncB_q[i] & ~prev_q[i];
			wire fall = ~syncB_q[i] & prev_q[i];
			assign edgeHit[i] = risingSel[i] ? rise : fall; // see RULE_08 see RULE_09
		end
	endgenerate

endmodule

// ===== pie_pkg.sv
// Package: constants and types shared by the prioritized interrupt enable block
package pie_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NUM_BANKS    = 4;
	localparam int BANK_W       = 2;
	localparam int SRC_PER_BANK = 8;
	localparam int NUM_SRC      = NUM_BANKS * SRC_PER_BANK;
	localparam int SRC_W        = 5;
	localparam int ADDR_W       = 8;
	localparam int DATA_W       = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFF    = 8'h00;
	localparam logic [ADDR_W-1:0] EDGE_OFF    = 8'h04;
	localparam logic [ADDR_W-1:0] SHARE_OFF   = 8'h08;
	localparam logic [ADDR_W-1:0] STAT_OFF    = 8'h0c;
	localparam logic [ADDR_W-1:0] MASK_OFF    = 8'h10;
	localparam logic [ADDR_W-1:0] CORE_OFF    = 8'h14;
	localparam logic [ADDR_W-1:0] BANK_BASE   = 8'h20;
	localparam logic [ADDR_W-1:0] BANK_END    = 8'h60;
	localparam int                BANK_SHIFT  = 4;
	localparam logic [3:0]        UPPER_OFF   = 4'h0;
	localparam logic [3:0]        LOWER_OFF   = 4'h4;
	localparam logic [3:0]        REQ_OFF     = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// Shared request lines: lines 1..7 sit in bits 7..1 of one bank
	localparam int SHARED_LINES = 7;
	localparam int SHARED_BANK  = 1;
	localparam int PORT2_LINES  = 4;
	localparam int NUM_PINS     = SHARED_LINES + PORT2_LINES;

	////////////////////////////////////////////////////////////////////////////////
	// Event status bits
	localparam int NUM_EVT      = 3;
	localparam int EVT_LATCH    = 0;
	localparam int EVT_DISMISS  = 1;
	localparam int EVT_TAKEN    = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [SRC_PER_BANK-1:0] ENABLE_RST = 8'h00;
	localparam logic [SRC_PER_BANK-1:0] REQ_RST    = 8'h00;
	localparam logic [SHARED_LINES-1:0] EDGE_RST   = 7'h00;
	localparam logic [SHARED_LINES-1:0] SHARE_RST  = 7'h00;
	localparam logic [NUM_EVT-1:0]      STAT_RST   = 3'h0;
	localparam logic [NUM_EVT-1:0]      MASK_RST   = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		LVL_OFF  = 2'h0,
		LVL_LOW  = 2'h1,
		LVL_NOM  = 2'h2,
		LVL_HIGH = 2'h3
	} pie_level_type;

	typedef struct packed {
		logic             valid;
		pie_level_type    level;
		logic [SRC_W-1:0] vector;
	} pie_core_irq_type;

	// Priority of one source from its upper and lower enable bits
	function automatic pie_level_type levelOf(input logic upper, input logic lower);
		pie_level_type lvl;
		lvl = LVL_OFF;
		case ({upper, lower})
			2'b01: lvl = LVL_LOW;
			2'b10: lvl = LVL_NOM;
			2'b11: lvl = LVL_HIGH;
			default: lvl = LVL_OFF;
		endcase
		return lvl;
	endfunction

endpackage

// ===== pie_prio_pick.sv
// Picks the pending, enabled source of highest priority for the core
`timescale 1ns/10ps
module pie_prio_pick #(
	parameter int N  = 32,
	parameter int SW = 5
) (
	// Pending requests and enables
	input  wire logic [N-1:0]  req,
	input  wire logic [N-1:0]  upper,
	input  wire logic [N-1:0]  lower,
	input  wire logic          globalEn,
	// Chosen source
	output logic               hit,
	output pie_pkg::pie_level_type level,
	output logic [SW-1:0]      vector
);

	pie_pkg::pie_level_type srcLvl [N];

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gLvl
			assign srcLvl[g] = pie_pkg::levelOf(upper[g], lower[g]); // see RULE_01
		end
	endgenerate

	// Ties go to the lowest source number; scanning downward lets it win last
	always_comb begin
		hit    = 1'b0;
		level  = pie_pkg::LVL_OFF;
		vector = '0;
		for (int i = N - 1; i >= 0; i--) begin
			// Disabled sources never reach the core
			if (globalEn && req[i] && srcLvl[i] != pie_pkg::LVL_OFF &&
				srcLvl[i] >= level) begin // see RULE_04 see RULE_06
				hit    = 1'b1;
				level  = srcLvl[i]; // see RULE_02 see RULE_03
				vector = SW'(i);
			end
		end
	end

endmodule
